// >>> dtc_timer_counter.sv
// two timer/counters with control and mode registers
`include "dtc_params.svh"
//
// Functional notes
// (R1) timer one mirrors timer zero, modes 0-2
// (R2) timer one uses mode upper nibble
// (R3) gate bit requires irq pin high
// (R4) source select: divided clock or falling edges
// (R5) all-ones to zero rollover sets flag
// (R6) mode 0: 5-bit prescaler feeds high byte
// (R7) mode 1: cascaded 16-bit counter
// (R8) mode 2: low byte reloads from high
// (R9) timer one mode 3 holds count
// (R10) timer zero mode 3 splits into two
// (R11) mode bits 00,01,10,11 select modes 0-3
// (R12) overflow flag cleared on vectoring
// (R13) timer interrupt needs own and global enable
// (R14) run bit turns timer on and off
// (R15) type bit: level when clear, edge set
// (R16) ext flag set on detect, edge-cleared
// (R17) control register bit layout fixed
// (R18) all registers reset to zero
// (R19) software stops timer before mode change
// (R20) timer one without interrupt in split; the code stops timer one from counting at all while timer zero is in mode 3
// (R21) timer ticks every six clocks
// (R22) counter samples pin per peripheral cycle
// (R23) setting run leaves count unchanged
// (R24) software write beats counter advance
module dtc_timer_counter import dtc_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  input wire logic zero_event_pin_in,
  input wire logic one_event_pin_in,
  input wire logic ext_irq_zero_pin_in,
  input wire logic ext_irq_one_pin_in,
  input wire logic [1:0] timer_irq_enable_in,
  input wire logic global_irq_enable_in,
  input wire logic [1:0] timer_irq_ack_in,
  input wire logic [1:0] ext_irq_ack_in,
  output logic [1:0] timer_irq_out,
  output logic [1:0] ext_irq_out
);
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] mode_select;
    dtc_count_s t0;
    dtc_count_s t1;
    logic [2:0] div;
    logic x0_prev;
    logic x1_prev;
  } dtc_state_s;
  localparam logic [2:0] PERIPH_LAST = 3'(`DTC_PERIPH_CLOCKS - 1);
  dtc_state_s state;
  dtc_state_s next_state;
  dtc_sfr_wr_s wr;
  dtc_mode_fields_s m0;
  dtc_mode_fields_s m1;
  logic tick;
  logic ev0_fall;
  logic ev1_fall;
  logic x0_level;
  logic x1_level;
  logic en0;
  logic en1;
  logic inc0;
  logic inc1;
  logic inc0h;
  logic ovf0;
  logic ovf1;
  logic ovf0h;
  logic [7:0] ctl;

  //////////////////////////////////////////////////////////////////////////
  // pin sampling
  dtc_pin_sampler u_ev0 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(tick),
    .pin_in(zero_event_pin_in),
    .level_out(),
    .fall_out(ev0_fall)
  );
  dtc_pin_sampler u_ev1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(tick),
    .pin_in(one_event_pin_in),
    .level_out(),
    .fall_out(ev1_fall)
  );
  dtc_pin_sampler u_x0 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(1'b1),
    .pin_in(ext_irq_zero_pin_in),
    .level_out(x0_level),
    .fall_out()
  );
  dtc_pin_sampler u_x1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(1'b1),
    .pin_in(ext_irq_one_pin_in),
    .level_out(x1_level),
    .fall_out()
  );

  //////////////////////////////////////////////////////////////////////////
  // decode and enables
  assign wr.wr = sfr_wr_in;
  assign wr.addr = sfr_addr_in;
  assign wr.wdata = sfr_wdata_in;
  assign m0 = dtc_mode_fields_s'(state.mode_select[3:0]);
  assign m1 = dtc_mode_fields_s'(state.mode_select[7:4]); // R2
  assign ctl = state.control;
  assign tick = (state.div == PERIPH_LAST); // R21
  // R3 R14
  assign en0 = ctl[`DTC_CTL_T0_RUN] & (~m0.gate | x0_level);
  assign en1 = ctl[`DTC_CTL_T1_RUN] & (~m1.gate | x1_level);
  // R4
  assign inc0 = en0 & (m0.source ? ev0_fall : tick);
  // R9: timer one holds in mode 3; R10: high half of split is timer only
  assign inc1 = en1 & (m1.mode != DTC_MODE_SPLIT)
    & (m1.source ? ev1_fall : tick) & (m0.mode != DTC_MODE_SPLIT);
  assign inc0h = ctl[`DTC_CTL_T1_RUN] & tick & (m0.mode == DTC_MODE_SPLIT);

  function automatic logic roll(input dtc_mode_e md, input dtc_count_s c);
    unique case (md) // R11
      DTC_MODE_13BIT: roll = (c.low[4:0] == 5'h1F) && (c.high == 8'hFF);
      DTC_MODE_16BIT: roll = (c.low == 8'hFF) && (c.high == 8'hFF);
      DTC_MODE_RELOAD, DTC_MODE_SPLIT: roll = (c.low == 8'hFF);
    endcase
  endfunction

  function automatic dtc_count_s step(input dtc_mode_e md,
                                      input dtc_count_s c);
    dtc_count_s r;
    r = c;
    unique case (md)
      DTC_MODE_13BIT: begin // R6
        r.low = (c.low & ~`DTC_PRESCALE_MASK) |
                ((c.low + 8'h01) & `DTC_PRESCALE_MASK);
        if (c.low[4:0] == 5'h1F) begin
          r.high = c.high + 8'h01;
        end
      end
      DTC_MODE_16BIT: begin // R7
        r.low = c.low + 8'h01;
        if (c.low == 8'hFF) begin
          r.high = c.high + 8'h01;
        end
      end
      DTC_MODE_RELOAD: begin // R8
        r.low = (c.low == 8'hFF) ? c.high : c.low + 8'h01;
      end
      DTC_MODE_SPLIT: begin
        r.low = c.low + 8'h01;
      end
    endcase
    return r;
  endfunction

  assign ovf0 = inc0 && roll(m0.mode, state.t0); // R5
  assign ovf1 = inc1 && roll(m1.mode, state.t1); // R1 R5
  assign ovf0h = inc0h && (state.t0.high == 8'hFF); // R10

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_state = state;
    next_state.div = tick ? 3'h0 : state.div + 3'h1;
    if (inc0) begin
      next_state.t0 = step(m0.mode, state.t0);
    end
    if (inc0h) begin
      next_state.t0.high = state.t0.high + 8'h01; // R10
    end
    if (inc1) begin
      next_state.t1 = step(m1.mode, state.t1); // R1
    end
    // external interrupt flags (R15 R16)
    next_state.x0_prev = x0_level;
    next_state.x1_prev = x1_level;
    if (ext_irq_ack_in[0] && ctl[`DTC_CTL_X0_TYPE]) begin
      next_state.control[`DTC_CTL_X0_FLAG] = 1'b0;
    end
    if (ext_irq_ack_in[1] && ctl[`DTC_CTL_X1_TYPE]) begin
      next_state.control[`DTC_CTL_X1_FLAG] = 1'b0;
    end
    if (!ctl[`DTC_CTL_X0_TYPE]) begin
      next_state.control[`DTC_CTL_X0_FLAG] = ~x0_level;
    end
    if (!ctl[`DTC_CTL_X1_TYPE]) begin
      next_state.control[`DTC_CTL_X1_FLAG] = ~x1_level;
    end
    // R12: vectoring clears overflow flags
    if (timer_irq_ack_in[0]) begin
      next_state.control[`DTC_CTL_T0_FLAG] = 1'b0;
    end
    if (timer_irq_ack_in[1]) begin
      next_state.control[`DTC_CTL_T1_FLAG] = 1'b0;
    end
    // software writes; R23 leaves counts alone, R24 write wins
    if (wr.wr) begin
      unique case (wr.addr)
        `DTC_OFS_CONTROL: next_state.control = wr.wdata; // R17
        `DTC_OFS_MODE: next_state.mode_select = wr.wdata;
        `DTC_OFS_T0_LOW: next_state.t0.low = wr.wdata; // R24
        `DTC_OFS_T1_LOW: next_state.t1.low = wr.wdata; // R24
        `DTC_OFS_T0_HIGH: next_state.t0.high = wr.wdata; // R24
        `DTC_OFS_T1_HIGH: next_state.t1.high = wr.wdata; // R24
        default: ;
      endcase
    end
    // hardware set wins over any clear in the same cycle
    if (ctl[`DTC_CTL_X0_TYPE] && state.x0_prev && !x0_level) begin
      next_state.control[`DTC_CTL_X0_FLAG] = 1'b1; // R16
    end
    if (ctl[`DTC_CTL_X1_TYPE] && state.x1_prev && !x1_level) begin
      next_state.control[`DTC_CTL_X1_FLAG] = 1'b1; // R16
    end
    if (ovf0) begin
      next_state.control[`DTC_CTL_T0_FLAG] = 1'b1; // R5
    end
    if (ovf1 || ovf0h) begin
      next_state.control[`DTC_CTL_T1_FLAG] = 1'b1; // R5 R10
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= '0; // R18
      state.x0_prev <= 1'b1;
      state.x1_prev <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port and interrupt requests
  always_comb begin
    sfr_hit_out = 1'b1;
    unique case (sfr_addr_in)
      `DTC_OFS_CONTROL: sfr_rdata_out = state.control;
      `DTC_OFS_MODE: sfr_rdata_out = state.mode_select;
      `DTC_OFS_T0_LOW: sfr_rdata_out = state.t0.low;
      `DTC_OFS_T1_LOW: sfr_rdata_out = state.t1.low;
      `DTC_OFS_T0_HIGH: sfr_rdata_out = state.t0.high;
      `DTC_OFS_T1_HIGH: sfr_rdata_out = state.t1.high;
      default: begin
        sfr_rdata_out = 8'h00;
        sfr_hit_out = 1'b0;
      end
    endcase
  end
  // R13
  assign timer_irq_out[0] = ctl[`DTC_CTL_T0_FLAG] & timer_irq_enable_in[0]
    & global_irq_enable_in;
  assign timer_irq_out[1] = ctl[`DTC_CTL_T1_FLAG] & timer_irq_enable_in[1]
    & global_irq_enable_in;
  assign ext_irq_out = {ctl[`DTC_CTL_X1_FLAG], ctl[`DTC_CTL_X0_FLAG]};

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence run_set_s;
    !state.control[`DTC_CTL_T0_RUN] ##1 state.control[`DTC_CTL_T0_RUN];
  endsequence
  keep_count_a: assert property (@(posedge clk_in) disable iff (rst_in) // R23
    run_set_s |-> state.t0 == $past(state.t0))
    else $error("count changed when run set");
  t0_flag_a: assert property (@(posedge clk_in) disable iff (rst_in) // R5
    ovf0 |=> state.control[`DTC_CTL_T0_FLAG])
    else $error("t0 overflow flag not set");
  irq_gate_a: assert property (@(posedge clk_in) disable iff (rst_in) // R13
    timer_irq_out[0] |-> global_irq_enable_in && timer_irq_enable_in[0])
    else $error("timer irq without enables");
  hold_one_a: assert property (@(posedge clk_in) disable iff (rst_in) // R9
    (m1.mode == DTC_MODE_SPLIT && !wr.wr) |=> state.t1 == $past(state.t1))
    else $error("timer one moved in hold mode");
  reload_a: assert property (@(posedge clk_in) disable iff (rst_in) // R8
    (ovf1 && m1.mode == DTC_MODE_RELOAD && !wr.wr)
      |=> state.t1.low == $past(state.t1.high))
    else $error("reload value wrong");
  stop_a: assert property (@(posedge clk_in) disable iff (rst_in) // R14
    (!ctl[`DTC_CTL_T0_RUN] && !wr.wr) |=>
      state.t0.low == $past(state.t0.low) &&
      (m0.mode == DTC_MODE_SPLIT || state.t0.high == $past(state.t0.high)))
    else $error("stopped timer zero moved");
  gate_a: assert property (@(posedge clk_in) disable iff (rst_in) // R3
    (m0.gate && !x0_level) |-> !inc0)
    else $error("gated timer advanced");
  tick_a: assert property (@(posedge clk_in) disable iff (rst_in) // R21
    tick |=> !tick [*5] ##1 tick)
    else $error("tick spacing not six");
  write_a: assert property (@(posedge clk_in) disable iff (rst_in) // R24
    (wr.wr && wr.addr == `DTC_OFS_T0_LOW) |=> state.t0.low == $past(wr.wdata))
    else $error("written low byte lost");
endmodule // dtc_timer_counter

// >>> dtc_params.svh
// register offsets, field positions, reset values and timing counts
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
`define DTC_OFS_CONTROL 8'h88
`define DTC_OFS_MODE 8'h89
`define DTC_OFS_T0_LOW 8'h8A
`define DTC_OFS_T1_LOW 8'h8B
`define DTC_OFS_T0_HIGH 8'h8C
`define DTC_OFS_T1_HIGH 8'h8D
`define DTC_CTL_T1_FLAG 7
`define DTC_CTL_T1_RUN 6
`define DTC_CTL_T0_FLAG 5
`define DTC_CTL_T0_RUN 4
`define DTC_CTL_X1_FLAG 3
`define DTC_CTL_X1_TYPE 2
`define DTC_CTL_X0_FLAG 1
`define DTC_CTL_X0_TYPE 0
`define DTC_MOD_GATE 3
`define DTC_MOD_SRC 2
`define DTC_MOD_HI 1
`define DTC_MOD_LO 0
`define DTC_RESET_BYTE 8'h00
`define DTC_PERIPH_CLOCKS 6
`define DTC_PRESCALE_MASK 8'h1F
`endif

// >>> dtc_pkg.sv
// types shared by the dual timer/counter block
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_MODE_13BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_e;
  typedef struct packed {
    logic gate;
    logic source;
    dtc_mode_e mode;
  } dtc_mode_fields_s;
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
  } dtc_count_s;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dtc_sfr_wr_s;
endpackage

// >>> dtc_pin_sampler.sv
// event pin synchroniser with per-cycle falling edge detect
module dtc_pin_sampler (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic pin_in,
  output logic level_out,
  output logic fall_out
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sample;
    logic prev;
  } dtc_samp_s;
  dtc_samp_s state;
  dtc_samp_s next_state;
  always_comb begin
    next_state = state;
    next_state.sync1 = pin_in;
    next_state.sync2 = state.sync1;
    if (tick_in) begin
      next_state.sample = state.sync2;
      next_state.prev = state.sample;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= '1;
    end else begin
      state <= next_state;
    end
  end
  assign level_out = state.sync2;
  // high in one sample, low in the next (R22)
  assign fall_out = tick_in & state.prev & ~state.sample;
endmodule // dtc_pin_sampler

// >>> dtc_pin_model.sv
// event pin driver standing in for the outside world
module dtc_pin_model (
  input wire logic clk_in,
  input wire logic [3:0] pulses_in,
  input wire logic start_in,
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int left = 0;
  int phase = 0;
  initial pin_out = 1'b1;
  // each level is held two peripheral cycles so every sample sees it
  always @(posedge clk_in) begin
    if (start_in) begin
      left <= int'(pulses_in);
      phase <= 0;
    end else if (left > 0) begin
      phase <= (phase == 23) ? 0 : phase + 1;
      pin_out <= (phase < 12) ? 1'b0 : 1'b1;
      if (phase == 23) begin
        left <= left - 1;
      end
    end
  end
endmodule // dtc_pin_model

// >>> tb_top.sv
// self-checking bench for the dual timer/counter
`include "dtc_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CT = `DTC_OFS_CONTROL;
  localparam logic [7:0] MD = `DTC_OFS_MODE;
  localparam logic [7:0] L0 = `DTC_OFS_T0_LOW;
  localparam logic [7:0] L1 = `DTC_OFS_T1_LOW;
  localparam logic [7:0] H0 = `DTC_OFS_T0_HIGH;
  localparam logic [7:0] H1 = `DTC_OFS_T1_HIGH;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr = 1'b0;
  logic x0 = 1'b1;
  logic gen = 1'b1;
  logic start = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [1:0] ten = 2'h3;
  logic [1:0] tack = 2'h0;
  logic [1:0] xack = 2'h0;
  logic [3:0] pulses = 4'h0;
  logic [7:0] rdata, v;
  logic [1:0] tirq, xirq;
  logic hit, ev0;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  always #10 clk_in = ~clk_in;
  dtc_timer_counter dtc_timer_counter_i (
    .clk_in(clk_in), .rst_in(rst_in), .sfr_wr_in(wr),
    .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .sfr_hit_out(hit), .zero_event_pin_in(ev0), .one_event_pin_in(1'b1),
    .ext_irq_zero_pin_in(x0), .ext_irq_one_pin_in(1'b1),
    .timer_irq_enable_in(ten), .global_irq_enable_in(gen),
    .timer_irq_ack_in(tack), .ext_irq_ack_in(xack),
    .timer_irq_out(tirq), .ext_irq_out(xirq));
  dtc_pin_model dtc_pin_model_i (.clk_in(clk_in), .pulses_in(pulses),
    .start_in(start), .pin_out(ev0));
  task automatic chk(input string s, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic r(input logic [7:0] a);
    @(posedge clk_in);
    addr <= a;
    #1 v = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    r(a);
    chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic ackp(input logic [1:0] t, input logic [1:0] x);
    @(posedge clk_in);
    tack <= t;
    xack <= x;
    @(posedge clk_in);
    tack <= 2'h0;
    xack <= 2'h0;
  endtask
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rc(CT + 8'(i), 8'h00);
    r(8'h90);
    chk("unmapped data", 8'h00, v);
    chk("unmapped hit", 8'h00, {7'h00, hit});
  endtask
  task automatic t_mode1();
    w(MD, 8'h01);
    w(L0, 8'hFE);
    w(H0, 8'hFF);
    w(CT, 8'h10);
    idle(14);
    rc(CT, 8'h30);
    chk("irq", 8'h01, {6'h00, tirq});
    gen <= 1'b0;
    idle(1);
    chk("irq masked", 8'h00, {6'h00, tirq});
    gen <= 1'b1;
    ackp(2'h1, 2'h0);
    rc(CT, 8'h10);
    w(CT, 8'h00);
    rc(H0, 8'h00);
    r(L0);
    idle(12);
    rc(L0, v);
  endtask
  task automatic t_mode0();
    w(MD, 8'h00);
    w(L0, 8'hFE);
    w(H0, 8'h00);
    w(CT, 8'h10);
    idle(14);
    w(CT, 8'h00);
    r(L0);
    chk("prescale", 8'h70, {1'b0, v[7:1]});
    rc(H0, 8'h01);
  endtask
  task automatic t_reload();
    w(MD, 8'h20);
    w(L1, 8'hFE);
    w(H1, 8'h80);
    w(CT, 8'h40);
    idle(14);
    rc(CT, 8'hC0);
    chk("irq one", 8'h02, {6'h00, tirq});
    w(CT, 8'h00);
    rc(H1, 8'h80);
    r(L1);
    chk("reload", 8'h40, {1'b0, v[7:1]});
  endtask
  task automatic t_count();
    w(MD, 8'h05);
    w(L0, 8'h00);
    w(H0, 8'h00);
    w(CT, 8'h10);
    pulses <= 4'h3;
    start <= 1'b1;
    idle(1);
    start <= 1'b0;
    idle(100);
    rc(L0, 8'h03);
    w(CT, 8'h00);
  endtask
  task automatic t_gate();
    w(MD, 8'h09);
    w(L0, 8'h00);
    x0 <= 1'b0;
    w(CT, 8'h10);
    idle(30);
    rc(L0, 8'h00);
    x0 <= 1'b1;
    idle(30);
    w(CT, 8'h00);
    r(L0);
    chk("gated count", 8'h01, {7'h00, v[7:2] == 6'h01});
  endtask
  task automatic t_split();
    w(MD, 8'h03);
    w(L0, 8'h00);
    w(H0, 8'hFE);
    w(CT, 8'h40);
    idle(14);
    rc(CT, 8'hC0);
    rc(L0, 8'h00);
    w(CT, 8'h00);
  endtask
  task automatic t_hold();
    w(MD, 8'h10);
    w(CT, 8'h40);
    idle(12);
    w(MD, 8'h30);
    r(L1);
    idle(12);
    rc(L1, v);
    w(CT, 8'h00);
  endtask
  task automatic t_ext();
    w(CT, 8'h01);
    x0 <= 1'b0;
    idle(5);
    rc(CT, 8'h03);
    x0 <= 1'b1;
    ackp(2'h0, 2'h1);
    rc(CT, 8'h01);
    w(CT, 8'h00);
    x0 <= 1'b0;
    idle(5);
    ackp(2'h0, 2'h1);
    rc(CT, 8'h02);
    chk("ext irq", 8'h01, {6'h00, xirq});
    x0 <= 1'b1;
    idle(5);
    rc(CT, 8'h00);
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    idle(6);
    rst_in <= 1'b0;
    t_reset();
    t_mode1();
    t_mode0();
    t_reload();
    t_count();
    t_gate();
    t_split();
    t_hold();
    t_ext();
    end_sim();
  end
endmodule // tb_top
